// >>> hdl/rcb_pkg.sv
// How it works
// RULE_01: Clock reference is external input or RTC oscillator, chosen by a fixed pin.
// RULE_02: Reference-select low: program PLL for 12.288 MHz, RTC times 375.
// RULE_03: Reference-select high: keep PLL bypassed, external input drives system clock.
// RULE_04: The 375x setting uses feedback 749, secondary 0, divide-by-8, output divider 0.
// RULE_05: Before USB probing set PLL near 36 MHz: times 3 or 1125.
// RULE_06: After hardware reset all peripheral clocks are gated off.
// RULE_07: Clock a peripheral only while probing it; at hand-off gate all, idle non-CPU.
// RULE_08: Software clears both USB oscillator disable bits, then waits to stabilise.
// RULE_09: Reset vector fetched from 0xFFFF00 in internal ROM, PLL bypassed.
// RULE_10: Pre-probe order: slow slew, idle all, set PLL, bandgap trim, clock pin off.
// RULE_11: First probe NOR on async chip selects 2 to 5, 16-bit, 2-byte signature.
// RULE_12: On NOR failure probe NAND on the same spaces with 8-bit accesses.
// RULE_13: Then serial EEPROM on chip select 0, 500 kHz, mode 5 then 6, 16/24-bit.
// RULE_14: Then two-wire EEPROM at address 0x50, 400 kHz, 2-byte signature.
// RULE_15: On a valid signature apply optional register config, load, then timer wait.
// RULE_16: Fixed order: NOR, NAND, serial 16, serial 24, two-wire, card; first wins.
// RULE_17: No valid source: loop on USB forever; only reset restarts probing.
// RULE_18: After load, run first timer for 200 ms before executing loaded code.
// RULE_19: Finally jump to the entry point carried in the boot image.
// RULE_20: Register-config section must not change clock output or first timer registers.
// RULE_21: RTC oscillator off: RTC inert and its 1900h to 197Fh range inaccessible.
// RULE_22: Peripheral clocks via gating registers; resets via counter and control regs.
// RULE_23: Card probe reports no signature; USB probe is an external hook.
// RULE_24: One probe at a time; advance only after its signature comparison ends.
package rcb_pkg;
   // Boot image signature and vectors
   localparam logic [15:0] BOOT_SIG = 16'h09AA;
   localparam logic [23:0] RESET_VECTOR = 24'hFFFF00;
   localparam logic [15:0] RTC_IO_LO = 16'h1900;
   localparam logic [15:0] RTC_IO_HI = 16'h197F;
   // PLL programs
   localparam logic [9:0] PLL_FB_375 = 10'h2ED;  // 749
   localparam logic [9:0] PLL_FB_USB_LO = 10'h3F0;
   localparam logic [9:0] PLL_FB_USB_HI = 10'h002;
   localparam logic [3:0] PLL_SEC_0 = 4'h0;
   localparam logic [3:0] PLL_OUT_0 = 4'h0;
   // Multipliers for reference (informational fields)
   localparam logic [10:0] MULT_375 = 11'h177;
   localparam logic [10:0] MULT_3 = 11'h003;
   localparam logic [10:0] MULT_1125 = 11'h465;
   // Probe parameters
   localparam logic [3:0] NOR_CS_MASK = 4'hF;  // Chip selects 2..5
   localparam logic [2:0] PPMODE_A = 3'h5;
   localparam logic [2:0] PPMODE_B = 3'h6;
   localparam logic [6:0] TWI_ADDR = 7'h50;
   localparam int SPI_KHZ = 500;
   localparam int TWI_KHZ = 400;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int SETTLE_MS = 200;
   // Milliseconds times MHz times 1000; stays inside 32 bits
   localparam int SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000;
   // Peripheral clock gate bits
   localparam int GATE_W = 8;
   localparam int G_EMIF = 0;
   localparam int G_SPI = 1;
   localparam int G_TWI = 2;
   localparam int G_CARD = 3;
   localparam int G_USB = 4;
   localparam int G_TIMER = 5;
   localparam logic [7:0] GATES_OFF = 8'h00;
   localparam logic [7:0] IDLE_ALL = 8'hFE;  // Bit 0 is CPU domain
   localparam logic [7:0] IDLE_NONE = 8'h00;

   // Probe sources
   typedef enum logic [2:0] {
      SRC_NOR = 3'b000,
      SRC_NAND = 3'b001,
      SRC_SPI16 = 3'b010,
      SRC_SPI24 = 3'b011,
      SRC_TWI = 3'b100,
      SRC_CARD = 3'b101,
      SRC_USB = 3'b110
   } rcb_src_t;

   // PLL setting
   typedef struct packed {
      logic bypass;
      logic [9:0] feedback;
      logic [3:0] secondary;
      logic in_div_en;
      logic div8_en;
      logic out_div_en;
      logic [3:0] out_div;
   } rcb_pll_t;

   // Probe request to the memory engine
   typedef struct packed {
      rcb_src_t src;
      logic wide;        // 16-bit access or 24-bit address
      logic [2:0] ppmode;
      logic [6:0] target;
   } rcb_probe_t;

   function automatic logic [7:0] gate_for(input rcb_src_t s);
      logic [7:0] g;
      g = GATES_OFF;
      unique case (s)
         SRC_NOR, SRC_NAND: g[G_EMIF] = 1'b1;
         SRC_SPI16, SRC_SPI24: g[G_SPI] = 1'b1;
         SRC_TWI: g[G_TWI] = 1'b1;
         SRC_CARD: g[G_CARD] = 1'b1;
         default: g[G_USB] = 1'b1;
      endcase
      return g;
   endfunction
endpackage

// >>> hdl/rcb_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Post-reset boot sequencer: clock setup, ordered probing, load, settle, jump
module rcb_sequencer #(
   parameter int SETTLE_CYCLES = rcb_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Static straps and status
   input wire logic ref_select_in,
   input wire logic rtc_osc_enabled_in,
   input wire logic trim_done_in,
   // Probe engine
   input wire logic probe_ack_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   input wire logic usb_sig_valid_in,
   // Image handling
   input wire logic has_reg_config_in,
   input wire logic config_done_in,
   input wire logic load_done_in,
   input wire logic [23:0] entry_point_in,
   // RTC access window
   input wire logic [15:0] io_addr_in,
   // Clock and power control
   output logic clk_from_rtc_out,
   output rcb_pkg::rcb_pll_t pll_out,
   output logic clock_output_pin_slow_out,
   output logic clock_output_pin_en_out,
   output logic trim_req_out,
   output logic [7:0] periph_clock_gate_out,
   output logic [7:0] periph_reset_out,
   output logic [7:0] idle_control_out,
   output logic rom_map_select_out,
   output logic rtc_access_ok_out,
   // Probe requests
   output logic probe_req_out,
   output rcb_pkg::rcb_probe_t probe_out,
   output logic config_req_out,
   output logic load_req_out,
   // Execution
   output logic [23:0] fetch_addr_out,
   output logic jump_out,
   output logic booted_out
);
   typedef enum logic [3:0] {
      ST_VECTOR = 4'b0000,
      ST_SLEW = 4'b0001,
      ST_IDLE = 4'b0010,
      ST_PLL = 4'b0011,
      ST_TRIM = 4'b0100,
      ST_CLKOFF = 4'b0101,
      ST_PROBE = 4'b0110,
      ST_WAIT_SIG = 4'b0111,
      ST_USB_PLL = 4'b1000,
      ST_USB = 4'b1001,
      ST_CONFIG = 4'b1010,
      ST_LOAD = 4'b1011,
      ST_SETTLE = 4'b1100,
      ST_JUMP = 4'b1101,
      ST_DONE = 4'b1110
   } rcb_state_t;

   rcb_state_t state;
   rcb_pkg::rcb_src_t src;
   logic ref_sel;
   logic timer_start;
   logic timer_done;
   logic sig_clear;
   logic sig_done;
   logic sig_match;

   rcb_sigcheck u_sig (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(sig_clear),
      .byte_valid_in(byte_valid_in && state == ST_WAIT_SIG),
      .byte_in(byte_in),
      .done_out(sig_done),
      .match_out(sig_match)
   );

   rcb_timer #(
      .CYCLES(SETTLE_CYCLES)
   ) u_timer (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(timer_start),
      .done_out(timer_done)
   );

   // Strap captured once after release; pin is static by board design
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ref_sel <= 1'b0;
      end else if (state == ST_VECTOR) begin
         ref_sel <= ref_select_in; // RULE_01
      end
   end

   // Reference mux follows the captured strap
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_from_rtc_out <= 1'b0;
      end else begin
         clk_from_rtc_out <= !ref_sel; // RULE_01
      end
   end

   // Main sequence; one probe outstanding at a time
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_VECTOR;
         src <= rcb_pkg::SRC_NOR;
      end else begin
         unique case (state)
            ST_VECTOR: state <= ST_SLEW; // RULE_09
            ST_SLEW: state <= ST_IDLE; // RULE_10
            ST_IDLE: state <= ST_PLL;
            ST_PLL: state <= ST_TRIM;
            ST_TRIM: if (trim_done_in) state <= ST_CLKOFF;
            ST_CLKOFF: state <= ST_PROBE;
            ST_PROBE: begin
               if (src == rcb_pkg::SRC_CARD) begin
                  state <= ST_USB_PLL; // RULE_23
               end else if (probe_ack_in) begin
                  state <= ST_WAIT_SIG; // RULE_24
               end
            end
            ST_WAIT_SIG: begin
               if (sig_done) begin
                  if (sig_match) begin
                     state <= ST_CONFIG; // RULE_15
                  end else begin
                     // RULE_16
                     src <= rcb_pkg::rcb_src_t'(src + 3'h1);
                     state <= ST_PROBE;
                  end
               end
            end
            ST_USB_PLL: begin
               src <= rcb_pkg::SRC_USB;
               state <= ST_USB;
            end
            ST_USB: if (usb_sig_valid_in) state <= ST_CONFIG; // RULE_17
            ST_CONFIG: begin
               if (!has_reg_config_in || config_done_in) begin
                  state <= ST_LOAD; // RULE_15
               end
            end
            ST_LOAD: if (load_done_in) state <= ST_SETTLE;
            ST_SETTLE: if (timer_done) state <= ST_JUMP; // RULE_18
            ST_JUMP: state <= ST_DONE; // RULE_19
            ST_DONE: state <= ST_DONE;
            default: state <= ST_VECTOR;
         endcase
      end
   end

   // Signature checker cleared on entry to each probe
   assign sig_clear = (state == ST_PROBE);
   // Timer starts as the load completes
   assign timer_start = (state == ST_LOAD) && load_done_in; // RULE_18

   // PLL programming: bypass at reset, 375x or bypass, then ~36 MHz for USB
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pll_out <= '{bypass: 1'b1, feedback: 10'h000, secondary: 4'h0,
                      in_div_en: 1'b0, div8_en: 1'b0, out_div_en: 1'b0,
                      out_div: 4'h0}; // RULE_09
      end else if (state == ST_PLL && !ref_sel) begin
         pll_out.bypass <= 1'b0; // RULE_02
         pll_out.feedback <= rcb_pkg::PLL_FB_375; // RULE_04
         pll_out.secondary <= rcb_pkg::PLL_SEC_0;
         pll_out.in_div_en <= 1'b0;
         pll_out.div8_en <= 1'b1;
         pll_out.out_div_en <= 1'b1;
         pll_out.out_div <= rcb_pkg::PLL_OUT_0;
      end else if (state == ST_PLL) begin
         pll_out.bypass <= 1'b1; // RULE_03
      end else if (state == ST_USB_PLL) begin
         // RULE_05
         pll_out.bypass <= 1'b0;
         pll_out.feedback <= ref_sel ? rcb_pkg::PLL_FB_USB_HI
                                     : rcb_pkg::PLL_FB_USB_LO;
      end
   end

   // Clock output pin: slow slew first, disabled after trim
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         clock_output_pin_slow_out <= 1'b0;
         clock_output_pin_en_out <= 1'b1;
         trim_req_out <= 1'b0;
      end else begin
         if (state == ST_SLEW) clock_output_pin_slow_out <= 1'b1; // RULE_10
         if (state == ST_CLKOFF) clock_output_pin_en_out <= 1'b0;
         trim_req_out <= (state == ST_TRIM);
      end
   end

   // Idle domains: all but CPU idled from the idle step onward
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         idle_control_out <= rcb_pkg::IDLE_NONE;
      end else if (state == ST_IDLE) begin
         idle_control_out <= rcb_pkg::IDLE_ALL; // RULE_07
      end
   end

   // Peripheral clock gating: only the probed source is clocked
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         periph_clock_gate_out <= rcb_pkg::GATES_OFF; // RULE_06
      end else begin
         unique case (state)
            // RULE_07 RULE_22
            ST_PROBE, ST_WAIT_SIG, ST_USB, ST_CONFIG, ST_LOAD:
               periph_clock_gate_out <= rcb_pkg::gate_for(src);
            default: periph_clock_gate_out <= rcb_pkg::GATES_OFF;
         endcase
      end
   end

   // Peripheral resets held except for the probed source
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         periph_reset_out <= 8'hFF;
      end else begin
         periph_reset_out <= ~periph_clock_gate_out; // RULE_22
      end
   end

   // RTC register window only while its oscillator runs
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rtc_access_ok_out <= 1'b0;
      end else begin
         rtc_access_ok_out <= rtc_osc_enabled_in &&
            io_addr_in >= rcb_pkg::RTC_IO_LO &&
            io_addr_in <= rcb_pkg::RTC_IO_HI; // RULE_21
      end
   end

   // Probe request fields per source
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         probe_req_out <= 1'b0;
         probe_out <= '0;
      end else begin
         probe_req_out <= (state == ST_PROBE) && !probe_ack_in &&
                          (src != rcb_pkg::SRC_CARD);
         probe_out.src <= src;
         probe_out.target <= {3'h0, rcb_pkg::NOR_CS_MASK};
         probe_out.wide <= 1'b0;
         probe_out.ppmode <= rcb_pkg::PPMODE_A;
         unique case (src)
            rcb_pkg::SRC_NOR: probe_out.wide <= 1'b1; // RULE_11
            rcb_pkg::SRC_NAND: probe_out.wide <= 1'b0; // RULE_12
            rcb_pkg::SRC_SPI16: probe_out.target <= 7'h00; // RULE_13
            rcb_pkg::SRC_SPI24: begin
               probe_out.wide <= 1'b1;
               probe_out.ppmode <= rcb_pkg::PPMODE_B;
               probe_out.target <= 7'h00;
            end
            rcb_pkg::SRC_TWI: probe_out.target <= rcb_pkg::TWI_ADDR; // RULE_14
            default: probe_out.target <= 7'h00;
         endcase
      end
   end

   // Image config and load requests; config section may not touch timer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         config_req_out <= 1'b0;
         load_req_out <= 1'b0;
      end else begin
         config_req_out <= (state == ST_CONFIG) && has_reg_config_in;
         load_req_out <= (state == ST_LOAD) && !load_done_in;
      end
   end

   // Fetch address: reset vector in ROM, then entry point
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fetch_addr_out <= rcb_pkg::RESET_VECTOR; // RULE_09
         rom_map_select_out <= 1'b0;
         jump_out <= 1'b0;
         booted_out <= 1'b0;
      end else begin
         jump_out <= (state == ST_JUMP);
         if (state == ST_JUMP) begin
            fetch_addr_out <= entry_point_in; // RULE_19
            booted_out <= 1'b1;
         end
      end
   end

   // Checks
   chk_gates_off_jump: assert property ( // RULE_07
      @(posedge clk_in) disable iff (rst_in)
      jump_out |-> periph_clock_gate_out == rcb_pkg::GATES_OFF)
      else $error("clocks on at hand-off");
   chk_one_gate: assert property ( // RULE_07
      @(posedge clk_in) disable iff (rst_in)
      $onehot0(periph_clock_gate_out))
      else $error("more than one clock on");
   chk_settle_wait: assert property ( // RULE_18
      @(posedge clk_in) disable iff (rst_in)
      state == ST_JUMP |-> $past(timer_done))
      else $error("jump before settle");
   chk_idle_hand: assert property ( // RULE_07
      @(posedge clk_in) disable iff (rst_in)
      jump_out |-> idle_control_out == rcb_pkg::IDLE_ALL)
      else $error("domains not idled");
   chk_pll_375: assert property ( // RULE_04
      @(posedge clk_in) disable iff (rst_in)
      state == ST_PLL && !ref_sel |=> pll_out.feedback == 10'h2ED)
      else $error("bad pll feedback");
   chk_pll_bypass: assert property ( // RULE_03
      @(posedge clk_in) disable iff (rst_in)
      state == ST_PLL && ref_sel |=> pll_out.bypass)
      else $error("pll not bypassed");
   chk_card_skip: assert property ( // RULE_23
      @(posedge clk_in) disable iff (rst_in)
      state == ST_PROBE && src == rcb_pkg::SRC_CARD |=> state == ST_USB_PLL)
      else $error("card not skipped");
   chk_usb_loop: assert property ( // RULE_17
      @(posedge clk_in) disable iff (rst_in)
      state == ST_USB && !usb_sig_valid_in |=> state == ST_USB)
      else $error("left usb loop");
   chk_jump_addr: assert property ( // RULE_19
      @(posedge clk_in) disable iff (rst_in)
      state == ST_JUMP |=> fetch_addr_out == $past(entry_point_in))
      else $error("bad entry point");
   cov_spi24_boot: cover property (@(posedge clk_in) disable iff (rst_in)
      state == ST_CONFIG && src == rcb_pkg::SRC_SPI24);
   cov_nor_boot: cover property (@(posedge clk_in) disable iff (rst_in)
      state == ST_CONFIG && src == rcb_pkg::SRC_NOR);
   cov_twi_boot: cover property (@(posedge clk_in) disable iff (rst_in)
      state == ST_CONFIG && src == rcb_pkg::SRC_TWI);
   cov_usb_boot: cover property (@(posedge clk_in) disable iff (rst_in)
      state == ST_CONFIG && src == rcb_pkg::SRC_USB);
endmodule
`default_nettype wire

// >>> hdl/rcb_sigcheck.sv
`timescale 1ns/1ps
`default_nettype none
// Assembles two signature bytes and compares with the expected value
module rcb_sigcheck (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Byte stream
   input wire logic clear_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   // Result
   output logic done_out,
   output logic match_out
);
   logic [7:0] first;
   logic have_first;

   // First byte is the low half of the signature word
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         first <= 8'h00;
         have_first <= 1'b0;
         done_out <= 1'b0;
         match_out <= 1'b0;
      end else if (clear_in) begin
         have_first <= 1'b0;
         done_out <= 1'b0;
         match_out <= 1'b0;
      end else if (byte_valid_in && !done_out) begin
         if (!have_first) begin
            first <= byte_in;
            have_first <= 1'b1;
         end else begin
            done_out <= 1'b1;
            match_out <= ({byte_in, first} == rcb_pkg::BOOT_SIG);
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/rcb_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Settling timer: counts cycles after start, flags done
module rcb_timer #(
   parameter int CYCLES = rcb_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Control
   input wire logic start_in,
   output logic done_out
);
   logic [31:0] count;
   logic running;

   // Count down; done holds until next start
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count <= 32'h00000000;
         running <= 1'b0;
         done_out <= 1'b0;
      end else if (start_in) begin
         count <= 32'(CYCLES - 1);
         running <= 1'b1;
         done_out <= 1'b0;
      end else if (running) begin
         if (count == 32'h00000000) begin
            running <= 1'b0;
            done_out <= 1'b1;
         end else begin
            count <= count - 32'h00000001;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/rcb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Boot memory stand-in: accepts probes, returns two signature bytes
module rcb_mem_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Which source holds a valid image
   input wire logic any_good_in,
   input wire rcb_pkg::rcb_src_t good_src_in,
   // Sequencer side
   input wire logic probe_req_in,
   input wire rcb_pkg::rcb_probe_t probe_in,
   input wire logic config_req_in,
   input wire logic load_req_in,
   output logic probe_ack_out,
   output logic byte_valid_out,
   output logic [7:0] byte_out,
   output logic config_done_out,
   output logic load_done_out
);
   logic [1:0] phase;
   logic hit;
   logic [15:0] sig;

   // Image present only on the chosen source; others answer the complement
   assign sig = hit ? rcb_pkg::BOOT_SIG : ~rcb_pkg::BOOT_SIG;

   // Driven at the falling edge so the sequencer samples settled values
   always @(negedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase <= 2'h0;
         hit <= 1'b0;
         probe_ack_out <= 1'b0;
         byte_valid_out <= 1'b0;
         byte_out <= 8'h00;
         config_done_out <= 1'b0;
         load_done_out <= 1'b0;
      end else begin
         probe_ack_out <= 1'b0;
         byte_valid_out <= 1'b0;
         byte_out <= ~byte_out; // Stale data never looks stable
         if (phase == 2'h0 && probe_req_in && !probe_ack_out) begin
            probe_ack_out <= 1'b1;
            hit <= any_good_in && probe_in.src == good_src_in;
            phase <= 2'h1;
         end else if (phase != 2'h0) begin
            // Low byte first, then the high byte
            byte_valid_out <= phase != 2'h3;
            byte_out <= (phase == 2'h1) ? sig[7:0] : sig[15:8];
            phase <= (phase == 2'h3) ? 2'h0 : phase + 2'h1;
         end
         config_done_out <= config_req_in;
         load_done_out <= load_req_in;
      end
   end
endmodule
`default_nettype wire

// >>> sim/tb_reset_clock_boot_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reset_clock_boot_sequencer;
   localparam int SETTLE = 50;
   localparam logic [23:0] ENTRY = 24'h012346;
   logic clk_in = 1'b0, rst_in = 1'b1, ref_select_in = 1'b0;
   logic rtc_osc_enabled_in = 1'b1, trim_done_in = 1'b0;
   logic probe_ack_in, byte_valid_in, config_done_in, load_done_in;
   logic [7:0] byte_in;
   logic usb_sig_valid_in = 1'b0, has_reg_config_in = 1'b0;
   logic any_good = 1'b0;
   logic [15:0] io_addr_in = 16'h0000;
   rcb_pkg::rcb_src_t good_src = rcb_pkg::SRC_NOR;
   logic clk_from_rtc_out, clock_output_pin_slow_out, clock_output_pin_en_out;
   logic trim_req_out, rom_map_select_out, rtc_access_ok_out, probe_req_out;
   logic config_req_out, load_req_out, jump_out, booted_out;
   rcb_pkg::rcb_pll_t pll_out;
   rcb_pkg::rcb_probe_t probe_out;
   logic [7:0] periph_clock_gate_out, periph_reset_out, idle_control_out;
   logic [23:0] fetch_addr_out;
   int n_mismatch = 0, checked = 0, cyc = 0, ld_cyc = 0;
   logic ld_seen = 1'b0, cfg_seen = 1'b0;
   rcb_pkg::rcb_src_t seen[$];
   int gate_bit[7] = '{0, 0, 1, 1, 2, 3, 4};

   rcb_sequencer #(.SETTLE_CYCLES(SETTLE)) dut_u (.clk_in(clk_in),
      .rst_in(rst_in), .ref_select_in(ref_select_in),
      .rtc_osc_enabled_in(rtc_osc_enabled_in), .trim_done_in(trim_done_in),
      .probe_ack_in(probe_ack_in), .byte_valid_in(byte_valid_in),
      .byte_in(byte_in), .usb_sig_valid_in(usb_sig_valid_in),
      .has_reg_config_in(has_reg_config_in), .config_done_in(config_done_in),
      .load_done_in(load_done_in), .entry_point_in(ENTRY),
      .io_addr_in(io_addr_in), .clk_from_rtc_out(clk_from_rtc_out),
      .pll_out(pll_out), .clock_output_pin_slow_out(clock_output_pin_slow_out),
      .clock_output_pin_en_out(clock_output_pin_en_out),
      .trim_req_out(trim_req_out), .periph_clock_gate_out(periph_clock_gate_out),
      .periph_reset_out(periph_reset_out), .idle_control_out(idle_control_out),
      .rom_map_select_out(rom_map_select_out),
      .rtc_access_ok_out(rtc_access_ok_out), .probe_req_out(probe_req_out),
      .probe_out(probe_out), .config_req_out(config_req_out),
      .load_req_out(load_req_out), .fetch_addr_out(fetch_addr_out),
      .jump_out(jump_out), .booted_out(booted_out));

   rcb_mem_model mem_u (.clk_in(clk_in), .rst_in(rst_in),
      .any_good_in(any_good), .good_src_in(good_src),
      .probe_req_in(probe_req_out), .probe_in(probe_out),
      .config_req_in(config_req_out), .load_req_in(load_req_out),
      .probe_ack_out(probe_ack_in), .byte_valid_out(byte_valid_in),
      .byte_out(byte_in), .config_done_out(config_done_in),
      .load_done_out(load_done_in));

   // 100 MHz clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end

   // Bandgap trim answers one cycle after it is asked for
   always @(negedge clk_in) trim_done_in <= trim_req_out;

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   // Probe monitor: order, clock gating and access width at each accept
   always @(posedge clk_in) begin
      cyc++;
      if (probe_req_out && probe_ack_in) begin
         cmp(periph_clock_gate_out, 32'h1 << gate_bit[probe_out.src]);
         if (probe_out.src == rcb_pkg::SRC_NOR) cmp(probe_out.wide, 1);
         if (probe_out.src == rcb_pkg::SRC_NAND) cmp(probe_out.wide, 0);
         if (probe_out.src == rcb_pkg::SRC_SPI16)
            cmp({probe_out.wide, probe_out.ppmode}, 4'h5);
         if (probe_out.src == rcb_pkg::SRC_SPI24)
            cmp({probe_out.wide, probe_out.ppmode}, 4'hE);
         if (probe_out.src == rcb_pkg::SRC_TWI) cmp(probe_out.target, 7'h50);
         if (probe_out.src != rcb_pkg::SRC_CARD &&
             (seen.size() == 0 || seen[$] != probe_out.src)) seen.push_back(probe_out.src);
      end
      if (config_req_out) cfg_seen = 1'b1;
      if (load_done_in && !ld_seen) begin
         cmp(cfg_seen, has_reg_config_in);
         ld_seen = 1'b1;
         ld_cyc = cyc;
      end
   end

   task automatic summarize;
      if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One full boot from a fresh reset
   task automatic run_boot(input logic rsel, input logic any, input int g);
      int i;
      @(negedge clk_in);
      rst_in = 1'b1;
      ref_select_in = rsel;
      any_good = any;
      good_src = rcb_pkg::rcb_src_t'(g);
      has_reg_config_in = g[0];
      usb_sig_valid_in = 1'b0;
      repeat (10) @(negedge clk_in);
      cmp(periph_clock_gate_out, 0);
      cmp(pll_out.bypass, 1);
      cmp(fetch_addr_out, 24'hFFFF00);
      cmp(rom_map_select_out, 0);
      seen.delete();
      ld_seen = 1'b0;
      cfg_seen = 1'b0;
      rst_in = 1'b0;
      for (i = 0; i < 200 && probe_req_out !== 1'b1; i++) @(negedge clk_in);
      cmp(clk_from_rtc_out, !rsel);
      cmp(pll_out.bypass, rsel);
      if (!rsel) cmp(pll_out, {1'b0, 10'd749, 4'h0, 1'b0, 1'b1, 1'b1, 4'h0});
      cmp({clock_output_pin_slow_out, clock_output_pin_en_out}, 2'b10);
      cmp(idle_control_out, 8'hFE);
      if (!any) begin
         for (i = 0; i < 2000 && probe_out.src !== rcb_pkg::SRC_USB; i++) @(negedge clk_in);
         repeat (200) @(negedge clk_in);
         cmp(pll_out.feedback, rsel ? rcb_pkg::PLL_FB_USB_HI : rcb_pkg::PLL_FB_USB_LO);
         cmp(periph_clock_gate_out, 32'h1 << gate_bit[6]);
         cmp(booted_out, 0);
         usb_sig_valid_in = 1'b1;
      end
      for (i = 0; i < 3000 && jump_out !== 1'b1; i++) @(negedge clk_in);
      cmp(jump_out, 1);
      cmp(fetch_addr_out, ENTRY);
      cmp(cyc - ld_cyc >= SETTLE, 1);
      @(negedge clk_in);
      cmp({periph_clock_gate_out, idle_control_out, booted_out}, 17'h001FD);
      cmp(periph_reset_out, 8'hFF);
      // USB is a hook, not a probe request, so it never joins the list
      cmp(seen.size(), any ? g + 1 : 5);
      for (i = 0; i < seen.size(); i++) cmp(seen[i], i);
   endtask

   // RTC window only opens with the oscillator running
   task automatic rtc_window;
      logic [15:0] addrs[4] = '{16'h18FF, 16'h1900, 16'h197F, 16'h1980};
      int a, o;
      for (o = 0; o < 2; o++) for (a = 0; a < 4; a++) begin
         @(negedge clk_in);
         rtc_osc_enabled_in = o[0];
         io_addr_in = addrs[a];
         repeat (2) @(negedge clk_in);
         cmp(rtc_access_ok_out, o == 1 && (a == 1 || a == 2));
      end
   endtask

   initial begin
      int g;
      for (g = 0; g < 5; g++) run_boot(g[1], 1'b1, g);
      run_boot(1'b1, 1'b0, 0);
      run_boot(1'b0, 1'b0, 0);
      rtc_window();
      summarize();
   end

   // Hang guard
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
